// ==== rtl/dacbo_regs.vh ====
// Register map, field layout and key values for the converter buffer op amp configuration block.
`ifndef DACBO_REGS_VH
`define DACBO_REGS_VH

`define DACBO_ADDR_W          32
`define DACBO_OFS_CH0_CTRL    32'hffff_0600
`define DACBO_OFS_CH1_CTRL    32'hffff_0608
`define DACBO_OFS_CH2_CTRL    32'hffff_0610
`define DACBO_OFS_CH3_CTRL    32'hffff_0618
`define DACBO_OFS_KEY_FIRST   32'hffff_0650
`define DACBO_OFS_CFG         32'hffff_0654
`define DACBO_OFS_KEY_SECOND  32'hffff_0658
`define DACBO_OFS_REF_SELECT  32'hffff_065c

`define DACBO_KEY_FIRST_VAL   8'h9a
`define DACBO_KEY_SECOND_VAL  8'h0c
`define DACBO_CFG_RST         4'h0
`define DACBO_CTRL_RST        8'h00
`define DACBO_CTRL_MASK       8'h73
`define DACBO_REFSEL_RST      1'b0
`define DACBO_CTRL_STRIDE     32'h0000_0008
`define DACBO_ENABLE_RST      4'h0
`define DACBO_TRISTATE_RST    4'hf
`define DACBO_RESERVED_RST    4'h0
`define DACBO_CONV_SRC_RST    8'h00

`define DACBO_RANGE_OFF       2'b00
`define DACBO_RANGE_RSVD      2'b01
`define DACBO_RANGE_VREF      2'b10
`define DACBO_RANGE_SUPPLY    2'b11

`define DACBO_SRC_NONE        2'b00
`define DACBO_SRC_INTERNAL    2'b01
`define DACBO_SRC_EXTERNAL    2'b10
`define DACBO_SRC_SUPPLY      2'b11

`endif

// ==== rtl/dacbo_config.v ====
// Converter buffer op amp configuration, reference decode and Wishbone register slave.
//
// Summary of operation
// (R1) Config bit 0: channel 0 buffer is op amp, inputs 0/1, output 0.
// (R2) Config bit 1: channel 1 buffer is op amp, inputs 2/3, output 1.
// (R3) Config bit 2: channel 2 buffer is op amp, inputs 4/5, output 2.
// (R4) Config bit 3: channel 3 buffer is op amp, inputs 8/9, output 3.
// (R5) Software should clear a channel's range field when in op amp mode.
// (R6) Software writes first key 0x9A, then config value, then second key 0x0C.
// (R7) Config commits only after the full correct key sequence in order.
// (R8) Config resets to zero; bits 7 to 4 are reserved and read zero.
// (R9) Select 0 and range 00: ADC external reference, converter powered down.
// (R10) Select 1 and range 00: ADC internal reference, converter powered down.
// (R11) Range 11: converter uses analog supply; ADC reference follows select bit.
// (R12) Select 1 and range 10: ADC and converter use internal reference.
// (R13) Select 1 and range 01: both use external; select 0 with 01 or 10 reserved.
// (R14) Range 00 off tristated, 01 reserved, 10 internal 2.5 V, 11 analog supply.
`default_nettype none
`include "dacbo_regs.vh"

module dacbo_config (
    input  wire        clock,
    input  wire        reset,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [31:0] wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         wb_err_o,
    output reg  [3:0]  opamp_mode_o,
    output reg  [3:0]  converter_enable_o,
    output reg  [3:0]  output_tristate_o,
    output reg  [3:0]  range_reserved_o,
    output reg  [7:0]  converter_ref_src_o,
    output reg  [1:0]  adc_ref_src_o
);

    // ------------------------------------------------------------------
    // Unlock sequence states
    // ------------------------------------------------------------------
    // Idle waits for the first key, keyed waits for the configuration
    // value, and staged holds that value until the second key arrives.
    localparam [1:0] SEQ_IDLE   = 2'b00;
    localparam [1:0] SEQ_KEYED  = 2'b01;
    localparam [1:0] SEQ_STAGED = 2'b10;

    // ------------------------------------------------------------------
    // Bus timing
    // ------------------------------------------------------------------
    // Every access is answered exactly one cycle after it is taken, with
    // ack for a mapped address and err for any other. The answer is
    // registered, so a request still held in the answer cycle is not taken
    // a second time; a strobe still high in the cycle after the answer is
    // taken as the next access, so no idle cycle is needed. Read data is driven only in the answer
    // cycle and is zero otherwise, so an idle bus shows no stale contents.

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    // The two key registers are write only and read as zero.
    // The op amp configuration holds four bits and reads zero above them.
    // The reference select holds a single bit in bit 0.
    // Each channel control keeps bits 6 to 4 and its two-bit range field.
    // Data registers of the converters live elsewhere and answer with err.

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------

    // Converter reference source for one channel.
    function [1:0] conv_src;
        input       refsel;
        input [1:0] range;
        begin
            case (range)
                `DACBO_RANGE_OFF:    conv_src = `DACBO_SRC_NONE;
                `DACBO_RANGE_SUPPLY: conv_src = `DACBO_SRC_SUPPLY;
                `DACBO_RANGE_VREF:   conv_src = refsel ? `DACBO_SRC_INTERNAL : `DACBO_SRC_NONE;
                `DACBO_RANGE_RSVD:   conv_src = refsel ? `DACBO_SRC_EXTERNAL : `DACBO_SRC_NONE;
                default:             conv_src = `DACBO_SRC_NONE;
            endcase
        end
    endfunction

    // Range codes that have no defined meaning with the given select bit.
    function is_reserved;
        input       refsel;
        input [1:0] range;
        begin
            is_reserved = !refsel && ((range == `DACBO_RANGE_RSVD) ||
                                      (range == `DACBO_RANGE_VREF));
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [3:0]  cfg_ff;
    reg  [3:0]  staged_ff;
    reg  [1:0]  seq_ff;
    reg         refsel_ff;
    reg  [7:0]  ctrl_ff [0:3];
    reg  [3:0]  nxt_cfg;
    reg  [3:0]  nxt_staged;
    reg  [1:0]  nxt_seq;
    reg  [31:0] nxt_rdata;
    reg         nxt_hit;

    wire        req     = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire        wr      = req && wb_we_i && wb_sel_i[0];
    wire        hit_k0  = (wb_adr_i == `DACBO_OFS_KEY_FIRST);
    wire        hit_cfg = (wb_adr_i == `DACBO_OFS_CFG);
    wire        hit_k1  = (wb_adr_i == `DACBO_OFS_KEY_SECOND);
    wire        hit_ref = (wb_adr_i == `DACBO_OFS_REF_SELECT);
    wire        key_first_ok  = hit_k0 && (wb_dat_i[7:0] == `DACBO_KEY_FIRST_VAL);
    wire        key_second_ok = hit_k1 && (wb_dat_i[7:0] == `DACBO_KEY_SECOND_VAL);
    wire [3:0]  hit_ctl;
    wire [1:0]  ref_of_adc;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ctl
            assign hit_ctl[g] = (wb_adr_i == (`DACBO_OFS_CH0_CTRL + `DACBO_CTRL_STRIDE * g));
        end
    endgenerate

    // ------------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------------
    // Any write with byte lane 0 selected, other than the expected next step or a
    // repeated first key while keyed, drops the sequence, so a stray access from
    // another task cannot leave the lock half open.
    always @* begin
        nxt_cfg    = cfg_ff;
        nxt_staged = staged_ff;
        nxt_seq    = seq_ff;
        if (wr) begin
            case (seq_ff)
                SEQ_IDLE: begin
                    // (R7) first key arms
                    if (key_first_ok)
                        nxt_seq = SEQ_KEYED;
                end
                SEQ_KEYED: begin
                    // (R8) reserved bits dropped
                    if (hit_cfg) begin
                        nxt_staged = wb_dat_i[3:0];
                        nxt_seq    = SEQ_STAGED;
                    end else if (key_first_ok) begin
                        nxt_seq = SEQ_KEYED;
                    end else begin
                        nxt_seq = SEQ_IDLE;
                    end
                end
                SEQ_STAGED: begin
                    // (R7) second key commits
                    if (key_second_ok)
                        nxt_cfg = staged_ff;
                    nxt_seq = SEQ_IDLE;
                end
                default: nxt_seq = SEQ_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read mux and address decode
    // ------------------------------------------------------------------
    always @* begin
        nxt_rdata = 32'h0000_0000;
        nxt_hit   = hit_k0 || hit_cfg || hit_k1 || hit_ref || (|hit_ctl);
        if (hit_cfg)
            nxt_rdata = {28'h000_0000, cfg_ff};
        else if (hit_ref)
            nxt_rdata = {31'h0000_0000, refsel_ff};
        else if (hit_ctl[0])
            nxt_rdata = {24'h00_0000, ctrl_ff[0]};
        else if (hit_ctl[1])
            nxt_rdata = {24'h00_0000, ctrl_ff[1]};
        else if (hit_ctl[2])
            nxt_rdata = {24'h00_0000, ctrl_ff[2]};
        else if (hit_ctl[3])
            nxt_rdata = {24'h00_0000, ctrl_ff[3]};
    end

    // ------------------------------------------------------------------
    // Bus answer and storage
    // ------------------------------------------------------------------
    integer i;
    always @(posedge clock) begin
        if (reset) begin
            cfg_ff    <= `DACBO_CFG_RST;
            staged_ff <= `DACBO_CFG_RST;
            seq_ff    <= SEQ_IDLE;
            refsel_ff <= `DACBO_REFSEL_RST;
            wb_ack_o  <= 1'b0;
            wb_err_o  <= 1'b0;
            wb_dat_o  <= 32'h0000_0000;
            for (i = 0; i < 4; i = i + 1)
                ctrl_ff[i] <= `DACBO_CTRL_RST;
        end else begin
            cfg_ff    <= nxt_cfg;
            staged_ff <= nxt_staged;
            seq_ff    <= nxt_seq;
            wb_ack_o  <= req && nxt_hit;
            wb_err_o  <= req && !nxt_hit;
            wb_dat_o  <= (req && !wb_we_i) ? nxt_rdata : 32'h0000_0000;
            if (wr && hit_ref)
                refsel_ff <= wb_dat_i[0];
            for (i = 0; i < 4; i = i + 1)
                if (wr && hit_ctl[i])
                    ctrl_ff[i] <= wb_dat_i[7:0] & `DACBO_CTRL_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Per-channel decode
    // ------------------------------------------------------------------
    // Op amp mode does not force the range field, but it holds that channel's
    // converter enable and tristate outputs low whatever the range field says.
    // An op amp channel still reports its reference source, because the
    // range field keeps its meaning once the buffer returns to normal use.
    wire [3:0]  nxt_enable;
    wire [3:0]  nxt_tristate;
    wire [3:0]  nxt_reserved;
    wire [7:0]  nxt_conv_src;

    generate
        for (g = 0; g < 4; g = g + 1) begin : g_out
            wire [1:0] rng = ctrl_ff[g][1:0];
            wire [1:0] src = conv_src(refsel_ff, rng);
            // (R14) range decode
            assign nxt_enable[g]   = !cfg_ff[g] && (src != `DACBO_SRC_NONE);
            assign nxt_tristate[g] = !cfg_ff[g] && (rng == `DACBO_RANGE_OFF);
            assign nxt_reserved[g] = is_reserved(refsel_ff, rng);
            // (R11) supply reference
            // (R12) internal reference
            // (R13) external overdrive
            assign nxt_conv_src[2*g +: 2] = src;
        end
    endgenerate

    // The ADC has a single reference, so channel 0 alone decides between
    // the internal and an overdriving external one; the other channels'
    // range codes never move it, a limitation software must keep in mind.
    // (R9) external ADC reference
    // (R10) internal ADC reference
    assign ref_of_adc = refsel_ff ?
        ((ctrl_ff[0][1:0] == `DACBO_RANGE_RSVD) ? `DACBO_SRC_EXTERNAL : `DACBO_SRC_INTERNAL) :
        `DACBO_SRC_EXTERNAL;

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    // Every output leaves from a flip-flop one cycle behind the registers,
    // so the analog switches never see a glitch of the decode above.
    always @(posedge clock) begin
        if (reset) begin
            opamp_mode_o        <= `DACBO_CFG_RST;
            converter_enable_o  <= `DACBO_ENABLE_RST;
            output_tristate_o   <= `DACBO_TRISTATE_RST;
            range_reserved_o    <= `DACBO_RESERVED_RST;
            converter_ref_src_o <= `DACBO_CONV_SRC_RST;
            adc_ref_src_o       <= `DACBO_SRC_EXTERNAL;
        end else begin
            // (R1) channel 0 op amp
            // (R2) channel 1 op amp
            // (R3) channel 2 op amp
            // (R4) channel 3 op amp
            opamp_mode_o        <= cfg_ff;
            converter_enable_o  <= nxt_enable;
            output_tristate_o   <= nxt_tristate;
            range_reserved_o    <= nxt_reserved;
            converter_ref_src_o <= nxt_conv_src;
            adc_ref_src_o       <= ref_of_adc;
        end
    end

endmodule
`default_nettype wire

// ==== bench/dacbo_config_asserts.sv ====
// Port-level checks for the converter buffer op amp register block.
`default_nettype none
`include "dacbo_regs.vh"
module dacbo_config_asserts (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic [3:0]  opamp_mode_o,
    input wire logic [3:0]  converter_enable_o,
    input wire logic [3:0]  output_tristate_o,
    input wire logic [3:0]  range_reserved_o,
    input wire logic [7:0]  converter_ref_src_o,
    input wire logic [1:0]  adc_ref_src_o
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    answer_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
        |=> wb_ack_o ^ wb_err_o) else $error("request not answered next cycle");
    no_stray_ack_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
        else $error("answer without a request");
    rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    // A mode change may only follow an acknowledged closing key write.
    cfg_commit_a: assert property ($changed(opamp_mode_o) |-> $past(wb_ack_o && wb_we_i
        && wb_adr_i == `DACBO_OFS_KEY_SECOND && wb_dat_i[7:0] == `DACBO_KEY_SECOND_VAL))
        else $error("op amp mode changed without unlock");
    opamp_off_a: assert property (((converter_enable_o | output_tristate_o)
        & opamp_mode_o) == 4'h0) else $error("op amp channel converter still active");
    tristate_off_a: assert property ((output_tristate_o & converter_enable_o) == 4'h0)
        else $error("tristated channel enabled");
    reserved_off_a: assert property ((range_reserved_o
        & (converter_enable_o | output_tristate_o)) == 4'h0) else $error("reserved range active");
    adc_ref_a: assert property (adc_ref_src_o == 2'b01 || adc_ref_src_o == 2'b10)
        else $error("adc reference not internal or external");
endmodule
`default_nettype wire

// ==== bench/dac_buffer_opamp_config_tb_top.sv ====
// Self-checking bench for the converter buffer op amp register block.
`default_nettype none
`include "dacbo_regs.vh"
module dac_buffer_opamp_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 0, reset = 1, cyc = 0, stb = 0, we = 0;
    logic [31:0] adr = 0, wdat = 0, v, lf = 32'h792b_0250;
    wire  [31:0] dat_o;
    wire         ack, err;
    wire  [3:0]  mode, en, ts, rsv;
    wire  [7:0]  src;
    wire  [1:0]  adc;
    int          cfg, seq, stg, refsel, err_count, num_checks;
    int          ctrl[4];
    logic [31:0] am[8] = '{32'hffff_0600, 32'hffff_0608, 32'hffff_0610, 32'hffff_0618,
                           32'hffff_0650, 32'hffff_0654, 32'hffff_0658, 32'hffff_065c};
    always #10 clock = ~clock;
    dacbo_config dut (.clock(clock), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .wb_err_o(err), .opamp_mode_o(mode), .converter_enable_o(en),
        .output_tristate_o(ts), .range_reserved_o(rsv), .converter_ref_src_o(src),
        .adc_ref_src_o(adc));
    function logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task summarize();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One classic cycle; the model follows the unlock sequence on every accepted write.
    task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        int n;
        logic [31:0] e;
        bit map;
        map = a inside {am};
        e = (a == `DACBO_OFS_CFG) ? cfg : (a == `DACBO_OFS_REF_SELECT) ? refsel : 0;
        if (map && a[31:5] == am[0][31:5]) e = ctrl[a[4:3]] & 'h73;
        @(posedge clock);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        for (n = 0; n < 20 && !(ack || err); n++) @(posedge clock);
        if (n == 20) begin err_count++; summarize(); end
        chk("err", {31'b0, !map}, {31'b0, err});
        if (!w) chk("rdata", e, dat_o);
        cyc <= 0; stb <= 0;
        if (w) begin
            if (a == `DACBO_OFS_KEY_FIRST) seq = (seq != 2 && d[7:0] == `DACBO_KEY_FIRST_VAL);
            else if (a == `DACBO_OFS_CFG && seq == 1) begin seq = 2; stg = d[3:0]; end
            else begin
                if (a == `DACBO_OFS_KEY_SECOND && seq == 2 && d[7:0] == `DACBO_KEY_SECOND_VAL)
                    cfg = stg;
                seq = 0;
            end
            if (a == `DACBO_OFS_REF_SELECT) refsel = d[0];
            if (map && a[31:5] == am[0][31:5]) ctrl[a[4:3]] = d[7:0];
        end
    endtask
    task outs();
        logic [3:0] en_e, ts_e, rs_e;
        logic [7:0] src_e, m;
        int r;
        repeat (2) @(posedge clock);
        #1;
        for (int i = 0; i < 4; i++) begin
            r = ctrl[i] & 3;
            ts_e[i] = !cfg[i] && r == 0;
            rs_e[i] = !refsel && (r == 1 || r == 2);
            en_e[i] = !cfg[i] && (r == 3 || (refsel && r != 0));
            m[2*i+:2] = cfg[i] ? 2'b00 : 2'b11;
            src_e[2*i+:2] = cfg[i] ? 0 : r == 3 ? 3 : (!refsel || r == 0) ? 0 : r == 2 ? 1 : 2;
        end
        chk("mode", cfg, mode);
        chk("enable", en_e, en);
        chk("tristate", ts_e, ts);
        chk("reserved", rs_e, rsv);
        chk("conv_src", src_e, src & m);
        chk("adc_src", refsel ? ((ctrl[0] & 3) == 1 ? 2 : 1) : 2, adc);
    endtask
    initial begin
        ctrl = '{0, 0, 0, 0};
        repeat (12) @(posedge clock);
        reset <= 0;
        outs();
        foreach (am[i]) bus(am[i], 0, 0);
        $display("reset test done");
        for (int k = 0; k < 80; k++) begin
            v = rnd();
            if (v[1:0] != 3) bus(`DACBO_OFS_KEY_FIRST, 1, v[1:0] == 1 ? v[31:24] : 'h9a);
            bus(`DACBO_OFS_CFG, 1, v[15:8]);
            if (v[1:0] == 2) bus(am[v[9:8]], 1, v[23:16]);
            if (v[1:0] == 3) bus(am[v[25:24]], 1, v[23:16]);
            if (v[1:0] == 3) bus(`DACBO_OFS_REF_SELECT, 1, v[26]);
            bus(`DACBO_OFS_KEY_SECOND, 1, v[16] ? 'h0c : v[31:24]);
            bus(`DACBO_OFS_CFG, 0, 0);
            outs();
        end
        $display("sequence test done");
        bus(`DACBO_OFS_KEY_FIRST, 1, 'h9a);
        bus(`DACBO_OFS_CFG, 1, 'h0f);
        bus(`DACBO_OFS_KEY_SECOND, 1, 'h0c);
        outs();
        for (int i = 0; i < 4; i++)
            if (cfg[i]) bus(am[i], 1, ctrl[i] & 'hfc);
        outs();
        $display("power down test done");
        bus(32'hffff_0604, 1, v);
        bus(32'hffff_0604, 0, 0);
        $display("unmapped test done");
        summarize();
    end
endmodule
bind dacbo_config dacbo_config_asserts u_chk (.clock(clock), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .opamp_mode_o(opamp_mode_o), .converter_enable_o(converter_enable_o),
    .output_tristate_o(output_tristate_o), .range_reserved_o(range_reserved_o),
    .converter_ref_src_o(converter_ref_src_o), .adc_ref_src_o(adc_ref_src_o));
`default_nettype wire
